// ==== bench/core_model.sv ====
/*
  partner model: the core running boot loader code, register steps and the program instruction.
  assumes the sequencer samples all inputs on the rising core_clk edge.
*/
`timescale 1ns/1ps
module core_model
  import seq_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic [7:0]  reg_rdata,
  output logic      [7:0]  reg_addr,
  output logic      [7:0]  reg_wdata,
  output logic             reg_write,
  output logic             reg_read,
  output logic             instr_exec,
  output logic      [15:0] z_pointer,
  output logic      [15:0] data_word_pair,
  output logic             eeprom_write
);
  // ************************************************************
  // core steps
  // ************************************************************
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    instr_exec = 1'b0;
    z_pointer = 16'h0000;
    data_word_pair = 16'h0000;
    eeprom_write = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // k counts edges from the control write to the instruction
  // model runs from the loader section, never reads the lower section while busy
  // the erase scenario targets upper page 7'h70 and expects the core to halt; no boot lock is modelled
  task automatic exec(input logic [7:0] c, input logic [6:0] p, input logic [5:0] w,
                      input logic [15:0] d, input int k);
    logic [15:0] z;
    z = {2'b00, p, w, 1'b0};
    wr(CTRL_OFFSET, c);
    repeat (k - 1) @(posedge core_clk);
    z_pointer <= z;
    data_word_pair <= d;
    instr_exec <= 1'b1;
    @(posedge core_clk);
    instr_exec <= 1'b0;
    z_pointer <= ~z;
    data_word_pair <= ~d;
  endtask : exec
  task automatic ee_pulse();
    @(posedge core_clk);
    eeprom_write <= 1'b1;
    @(posedge core_clk);
    eeprom_write <= 1'b0;
  endtask : ee_pulse
endmodule : core_model

// ==== bench/testbench.sv ====
/*
  self-checking bench for the self-program sequencer driven by a core model.
  assumes the program phase is shortened to 20 cycles.
*/
`timescale 1ns/1ps
module testbench;
  import seq_pkg::*;
  localparam logic [7:0] LD = {2'b00, CMD_LOAD};
  localparam logic [7:0] ER = {2'b00, CMD_ERASE};
  localparam logic [7:0] WR = {2'b00, CMD_WRITE};
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
  logic        reg_write, reg_read, instr_exec, eeprom_write, core_halt, rww_read_block;
  logic        flash_erase, flash_write, flash_wvalid, irq, halt_seen, block_seen;
  logic [15:0] z_pointer, data_word_pair, flash_wdata;
  logic [15:0] seen_word [64];
  logic [6:0]  flash_page, page_seen;
  logic [5:0]  flash_waddr;
  int          n_errors = 0;
  int          checks_done = 0;
  int          n_erase = 0;
  always #2 core_clk = ~core_clk;
  self_program_flash_sequencer #(.PROG_CYCLES_P(20)) self_program_flash_sequencer_i (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .instr_exec(instr_exec),
    .z_pointer(z_pointer), .data_word_pair(data_word_pair), .eeprom_write(eeprom_write),
    .core_halt(core_halt), .rww_read_block(rww_read_block), .flash_erase(flash_erase),
    .flash_write(flash_write), .flash_page(flash_page), .flash_wvalid(flash_wvalid),
    .flash_waddr(flash_waddr), .flash_wdata(flash_wdata), .irq(irq));
  core_model core_model_i (
    .core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .instr_exec(instr_exec), .z_pointer(z_pointer),
    .data_word_pair(data_word_pair), .eeprom_write(eeprom_write));
  // ************************************************************
  // flash side monitor
  // ************************************************************
  always @(posedge core_clk) begin
    if (flash_wvalid) begin
      seen_word[flash_waddr] <= flash_wdata;
    end
    if (flash_erase || flash_write) begin
      page_seen <= flash_page;
      halt_seen <= core_halt;
      block_seen <= rww_read_block;
    end
    if (flash_erase) begin
      n_erase <= n_erase + 1;
    end
  end
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic reen();
    core_model_i.wr(CTRL_OFFSET, 8'h11);
  endtask : reen
  task automatic op(input logic [7:0] c, input logic [6:0] p, input logic [5:0] w,
                    input logic [15:0] d, input int k);
    foreach (seen_word[i]) seen_word[i] = 16'h0000;
    core_model_i.exec(c, p, w, d, k);
    for (int i = 0; i < 100; i++) begin
      core_model_i.rd(STATUS_OFFSET, v);
      if (v[0] === 1'b1) break;
    end
    check("done", v[0], 1'b1);
    core_model_i.wr(STATUS_OFFSET, 8'h01);
  endtask : op
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    check("halt", core_halt, 1'b0);
    core_model_i.rd(CTRL_OFFSET, v);
    check("ctrl", v, 8'h00);
    core_model_i.wr(8'h0C, 8'hFF);
    core_model_i.rd(8'h0C, v);
    check("unmapped", v, 8'h00);
  endtask : t_reset
  task automatic t_load_write();
    op(LD, 7'h00, 6'h00, 16'h1234, 1);
    op(LD, 7'h00, LAST_WORD, 16'hA5C3, 4);
    op(WR, 7'h10, 6'h00, 16'h7777, 2);
    check("word0", seen_word[0], 16'h1234);
    check("word63", seen_word[63], 16'hA5C3);
    check("word1", seen_word[1], ERASED_WORD);
    check("wpage", page_seen, 7'h10);
    check("whalt", halt_seen, 1'b0);
    check("wblock", block_seen, 1'b1);
    core_model_i.rd(CTRL_OFFSET, v);
    check("busy", v[BUSY_BIT], 1'b1);
    check("pin", rww_read_block, 1'b1);
    reen();
    core_model_i.rd(CTRL_OFFSET, v);
    check("busy0", v[BUSY_BIT], 1'b0);
    op(WR, 7'h10, 6'h00, 16'h0000, 3);
    check("cleared", seen_word[0], ERASED_WORD);
    reen();
  endtask : t_load_write
  task automatic t_erase();
    int n;
    n = n_erase;
    op(ER, 7'h70, 6'h00, 16'h5555, 4);
    check("erases", n_erase - n, 16'h0001);
    check("epage", page_seen, 7'h70);
    check("ehalt", halt_seen, 1'b1);
    check("eblock", block_seen, 1'b1);
    check("halt_end", core_halt, 1'b0);
    reen();
    n = n_erase;
    core_model_i.exec(ER, 7'h20, 6'h00, 16'h0000, 5);
    core_model_i.rd(CTRL_OFFSET, v);
    check("cmd_clear", v, 8'h00);
    check("no_erase", n_erase - n, 16'h0000);
  endtask : t_erase
  task automatic t_discard();
    op(LD, 7'h00, 6'h03, 16'hBEEF, 1);
    core_model_i.ee_pulse();
    op(LD, 7'h00, 6'h02, 16'h1111, 2);
    op(WR, 7'h11, 6'h00, 16'h0000, 1);
    check("lost", seen_word[3], ERASED_WORD);
    check("kept", seen_word[2], 16'h1111);
    reen();
    op(LD, 7'h00, 6'h04, 16'h0F0F, 2);
    reen();
    op(WR, 7'h11, 6'h00, 16'h0000, 1);
    check("reen_clear", seen_word[4], ERASED_WORD);
    reen();
  endtask : t_discard
  task automatic t_irq();
    core_model_i.wr(CTRL_OFFSET, 8'h80);
    settle(2);
    check("irq_ie", irq, 1'b1);
    core_model_i.wr(CTRL_OFFSET, 8'h00);
    settle(2);
    check("irq_off", irq, 1'b0);
    core_model_i.wr(MASK_OFFSET, 8'h01);
    core_model_i.exec(LD, 7'h00, 6'h00, 16'h2222, 1);
    settle(3);
    check("irq_done", irq, 1'b1);
    core_model_i.wr(MASK_OFFSET, 8'h00);
    settle(2);
    check("irq_mask", irq, 1'b0);
    core_model_i.wr(MASK_OFFSET, 8'h01);
    core_model_i.wr(STATUS_OFFSET, 8'h01);
    settle(2);
    check("irq_clr", irq, 1'b0);
    reen();
  endtask : t_irq
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_load_write();
    t_erase();
    t_discard();
    t_irq();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    print_verdict();
  end
endmodule : testbench

// ==== verilog/page_buffer.sv ====
/*
  temporary page buffer: one word per slot, slots never loaded read as erased.
  assumes the owner loads each slot at most once between clears.
*/
`timescale 1ns/1ps
module page_buffer
  import seq_pkg::*;
(
  input wire logic          core_clk,
  input wire logic          reset,
  page_buffer_if.store      bus
);
  logic [15:0]           mem_q [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] valid_q;

  // ************************************************************
  // storage
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (bus.wr_en) begin
      mem_q[bus.wr_slot] <= bus.wr_data;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      valid_q <= '0;
    end else if (bus.clear) begin
      valid_q <= '0;
    end else if (bus.wr_en) begin
      valid_q[bus.wr_slot] <= 1'b1;
    end
  end

  assign bus.rd_data = valid_q[bus.rd_slot] ? mem_q[bus.rd_slot] : ERASED_WORD;
  assign bus.loaded  = |valid_q;

  // ************************************************************
  // checks
  // ************************************************************
  clear_empties_a: assert property (@(posedge core_clk) disable iff (reset)
    bus.clear |=> !bus.loaded) else $error("buffer not empty after clear");
endmodule : page_buffer

// ==== verilog/page_buffer_if.sv ====
/*
  interface between the sequencer and its temporary page buffer.
  assumes both ends run on core_clk.
*/
`timescale 1ns/1ps
interface page_buffer_if;
  logic        clear;
  logic        wr_en;
  logic [5:0]  wr_slot;
  logic [15:0] wr_data;
  logic [5:0]  rd_slot;
  logic [15:0] rd_data;
  logic        loaded;
  modport owner (output clear, output wr_en, output wr_slot, output wr_data, output rd_slot,
                 input rd_data, input loaded);
  modport store (input clear, input wr_en, input wr_slot, input wr_data, input rd_slot,
                 output rd_data, output loaded);
endinterface : page_buffer_if

// ==== verilog/self_program_flash_sequencer.sv ====
/*
  self-program sequencer: command register, four-cycle instruction window,
  page erase, page load and page write, section blocking, core halt, interrupt.
  assumes the core pulses instr_exec for one cycle when it runs the self-program
  instruction, with z_pointer and data_word_pair valid in that cycle.
*/
`timescale 1ns/1ps
// Summary of operation
// - control write of X0000011 then instruction within four cycles erases a page.
// - lower-section targets leave the upper section readable; upper targets halt the core.
// - pattern 00000001 then instruction loads data pair into slot given by pointer.
// - buffer clears after page write, on re-enable write, and on reset.
// - a data-eeprom write during loading discards all loaded words.
// - pattern X0000101 then instruction within four cycles writes the page.
// - interrupt stays asserted while enabled and the enable bit reads clear.
// - during erase or write the rww section is blocked and busy is set.
// - busy stays set after programming until software writes re-enable.
module self_program_flash_sequencer
  import seq_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES
)(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic        instr_exec,
  input  wire logic [15:0] z_pointer,
  input  wire logic [15:0] data_word_pair,
  input  wire logic        eeprom_write,
  output logic             core_halt,
  output logic             rww_read_block,
  output logic             flash_erase,
  output logic             flash_write,
  output logic      [6:0]  flash_page,
  output logic             flash_wvalid,
  output logic      [5:0]  flash_waddr,
  output logic      [15:0] flash_wdata,
  output logic             irq
);
  typedef enum {st_idle, st_stream, st_program} state_type;

  state_type         state_q;
  logic      [5:0]   cmd_q;
  logic              ie_q;
  logic              busy_q;
  logic      [2:0]   window_q;
  logic      [CNT_W-1:0] cnt_q;
  logic      [5:0]   stream_q;
  logic              is_erase_q;
  logic              done_q;
  logic              mask_q;
  logic      [7:0]   rdata_q;
  logic              halt_q;
  logic              erase_q;
  logic              write_q;
  logic      [6:0]   page_q;
  logic              wvalid_q;
  logic      [5:0]   waddr_q;
  logic      [15:0]  wdata_q;
  logic              irq_q;

  page_buffer_if buf_if ();

  page_buffer u_buffer (
    .core_clk (core_clk),
    .reset    (reset),
    .bus      (buf_if.store)
  );

  // ************************************************************
  // decode
  // ************************************************************
  function automatic logic hit_reg(input logic [7:0] addr, input logic [7:0] offset);
    hit_reg = (addr == offset);
  endfunction : hit_reg

  wire        ctrl_wr    = reg_write && hit_reg(reg_addr, CTRL_OFFSET);
  wire        status_wr  = reg_write && hit_reg(reg_addr, STATUS_OFFSET);
  wire        mask_wr    = reg_write && hit_reg(reg_addr, MASK_OFFSET);
  wire        idle       = (state_q == st_idle);
  wire        window_open = (window_q != 3'h0);
  wire        exec_hit   = instr_exec && window_open && idle;
  wire        reen_wr    = ctrl_wr && idle && reg_wdata[REEN_BIT] && reg_wdata[EN_BIT];
  wire [6:0]  z_page     = z_pointer[Z_PAGE_LSB +: PAGE_W];
  wire [5:0]  z_word     = z_pointer[Z_WORD_LSB +: WORD_W];
  wire        start_erase = exec_hit && (cmd_q == CMD_ERASE);
  wire        start_write = exec_hit && (cmd_q == CMD_WRITE);
  wire        do_load     = exec_hit && (cmd_q == CMD_LOAD);
  wire        target_upper = (z_page >= UPPER_FIRST_PAGE);
  wire        prog_end    = (state_q == st_program) && (cnt_q == CNT_W'(PROG_CYCLES_P - 1));
  wire        stream_end  = (state_q == st_stream) && (stream_q == LAST_WORD);
  wire        expire      = (window_q == 3'h1) && !exec_hit && !ctrl_wr;
  wire        load_done   = do_load || (exec_hit && !start_erase && !start_write);
  wire        done_set    = prog_end || load_done;
  wire [7:0]  ctrl_view   = {ie_q, busy_q, cmd_q};
  wire [7:0]  read_mux    = hit_reg(reg_addr, CTRL_OFFSET)   ? ctrl_view :
                            hit_reg(reg_addr, STATUS_OFFSET) ? {7'h00, done_q} :
                            hit_reg(reg_addr, MASK_OFFSET)   ? {7'h00, mask_q} : 8'h00;

  assign buf_if.wr_en   = do_load;
  assign buf_if.wr_slot = z_word;
  assign buf_if.wr_data = data_word_pair;
  assign buf_if.rd_slot = stream_q;
  assign buf_if.clear   = reen_wr || (prog_end && !is_erase_q)
                          || (eeprom_write && buf_if.loaded && idle);

  // ************************************************************
  // command register and instruction window
  // ************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cmd_q    <= CMD_RESET;
      ie_q     <= 1'b0;
      window_q <= 3'h0;
    end else begin
      if (ctrl_wr) begin
        ie_q <= reg_wdata[IE_BIT];
      end
      if (ctrl_wr && idle && !reen_wr) begin
        cmd_q    <= reg_wdata[5:0];
        window_q <= EXEC_WINDOW;
      end else if (reen_wr || load_done || prog_end || expire) begin
        cmd_q    <= CMD_RESET;
        window_q <= 3'h0;
      end else if (exec_hit) begin
        window_q <= 3'h0;
      end else if (window_open) begin
        window_q <= window_q - 3'h1;
      end
    end
  end

  // ************************************************************
  // operation sequencing
  // ************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q    <= st_idle;
      cnt_q      <= '0;
      stream_q   <= '0;
      is_erase_q <= 1'b0;
      busy_q     <= 1'b0;
      halt_q     <= 1'b0;
      page_q     <= '0;
    end else begin
      case (state_q)
        st_idle: begin
          cnt_q    <= '0;
          stream_q <= '0;
          if (start_erase || start_write) begin
            state_q    <= start_erase ? st_program : st_stream;
            is_erase_q <= start_erase;
            busy_q     <= 1'b1;
            halt_q     <= target_upper;
            page_q     <= z_page;
          end else if (reen_wr) begin
            busy_q <= 1'b0;
          end
        end
        st_stream: begin
          stream_q <= stream_q + 6'h01;
          if (stream_end) begin
            state_q <= st_program;
          end
        end
        st_program: begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (prog_end) begin
            state_q <= st_idle;
            halt_q  <= 1'b0;
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  // ************************************************************
  // flash strobes and write stream
  // ************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      erase_q  <= 1'b0;
      write_q  <= 1'b0;
      wvalid_q <= 1'b0;
      waddr_q  <= '0;
      wdata_q  <= '0;
    end else begin
      erase_q  <= start_erase;
      write_q  <= stream_end;
      wvalid_q <= (state_q == st_stream);
      waddr_q  <= stream_q;
      wdata_q  <= buf_if.rd_data;
    end
  end

  // ************************************************************
  // status, mask, interrupt and read port
  // ************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      done_q  <= STATUS_RESET;
      mask_q  <= MASK_RESET;
      rdata_q <= 8'h00;
      irq_q   <= 1'b0;
    end else begin
      done_q  <= done_set || (done_q && !(status_wr && reg_wdata[0]));
      if (mask_wr) begin
        mask_q <= reg_wdata[0];
      end
      rdata_q <= reg_read ? read_mux : 8'h00;
      irq_q   <= (ie_q && !cmd_q[EN_BIT]) || (done_q && mask_q);
    end
  end

  assign reg_rdata      = rdata_q;
  assign core_halt      = halt_q;
  assign rww_read_block = busy_q;
  assign flash_erase    = erase_q;
  assign flash_write    = write_q;
  assign flash_page     = page_q;
  assign flash_wvalid   = wvalid_q;
  assign flash_waddr    = waddr_q;
  assign flash_wdata    = wdata_q;
  assign irq            = irq_q;

  // ************************************************************
  // checks
  // ************************************************************
  erase_starts_a: assert property (@(posedge core_clk) disable iff (reset)
    start_erase |=> flash_erase && rww_read_block && (state_q == st_program))
    else $error("erase did not start");
  halt_section_a: assert property (@(posedge core_clk) disable iff (reset)
    (start_erase || start_write) |=> (core_halt == $past(target_upper)))
    else $error("halt does not follow target section");
  load_writes_a: assert property (@(posedge core_clk) disable iff (reset)
    (window_q == 3'h0) |-> !buf_if.wr_en) else $error("load outside window");
  write_clears_a: assert property (@(posedge core_clk) disable iff (reset)
    (prog_end && !is_erase_q) |-> buf_if.clear) else $error("buffer kept after write");
  eeprom_discard_a: assert property (@(posedge core_clk) disable iff (reset)
    (eeprom_write && idle && buf_if.loaded) |=> !buf_if.loaded)
    else $error("loaded words survived eeprom write");
  write_stream_a: assert property (@(posedge core_clk) disable iff (reset)
    start_write |=> (state_q == st_stream) [*8]) else $error("page stream cut short");
  irq_level_a: assert property (@(posedge core_clk) disable iff (reset)
    ($past(ie_q) && !$past(cmd_q[EN_BIT])) |-> irq) else $error("ready interrupt missing");
  busy_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    (busy_q && !reen_wr) |=> busy_q) else $error("busy dropped without re-enable");
  window_expiry_a: assert property (@(posedge core_clk) disable iff (reset)
    (ctrl_wr && idle && !reen_wr) ##1 (!instr_exec && !ctrl_wr) [*4] |=> (cmd_q == CMD_RESET) && idle)
    else $error("command survived an unused window");
endmodule : self_program_flash_sequencer

// ==== verilog/spm_pkg.sv ====
/*
  constants for the self-program flash sequencer: register map, command codes,
  page geometry and program timing.
  assumes a 250 MHz core clock and an 8-bit register port.
*/
package seq_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] MASK_OFFSET   = 8'h08;
  localparam int         IE_BIT        = 7;
  localparam int         BUSY_BIT      = 6;
  localparam int         REEN_BIT      = 4;
  localparam int         EN_BIT        = 0;
  localparam logic [5:0] CMD_RESET     = 6'h00;
  localparam logic [5:0] CMD_LOAD      = 6'h01;
  localparam logic [5:0] CMD_ERASE     = 6'h03;
  localparam logic [5:0] CMD_WRITE     = 6'h05;
  localparam logic [2:0] EXEC_WINDOW   = 3'h4;
  localparam logic       STATUS_RESET  = 1'h0;
  localparam logic       MASK_RESET    = 1'h0;
  // ************************************************************
  // page geometry
  // ************************************************************
  localparam int         WORD_W          = 6;
  localparam int         PAGE_W          = 7;
  localparam int         PAGE_WORDS      = 64;
  localparam int         Z_WORD_LSB      = 1;
  localparam int         Z_PAGE_LSB      = 7;
  localparam logic [6:0] UPPER_FIRST_PAGE = 7'h70;
  localparam logic [5:0] LAST_WORD       = 6'h3F;
  localparam logic [15:0] ERASED_WORD    = 16'hFFFF;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int PROG_TIME_NS  = 4000000;
  localparam int PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W         = 20;
endpackage : seq_pkg
